// ===== hdl/sld_pkg.sv
// Constants for the deterministic latency and alignment block
package sld_pkg;
	localparam logic [11:0] SLD_ADDR_CAPTURE   = 12'h120;
	localparam logic [11:0] SLD_ADDR_MONITOR   = 12'h128;
	localparam logic [11:0] SLD_ADDR_SYNCMODE  = 12'h1FF;
	localparam logic [11:0] SLD_ADDR_LANERATE  = 12'h56E;
	localparam logic [11:0] SLD_ADDR_LMFC_OFS  = 12'h578;
	localparam logic [11:0] SLD_ADDR_SUBCLASS  = 12'h590;
	localparam logic [11:0] SLD_ADDR_LINKCFG   = 12'h5A0;
	localparam logic [11:0] SLD_ADDR_STATUS    = 12'h5A4;
	localparam int SLD_BIT_SUBCLASS  = 5;
	localparam int SLD_BIT_TRANS     = 4;
	localparam int SLD_BIT_EDGE      = 3;
	localparam int SLD_BIT_SYNCMODE  = 0;
	localparam int SLD_BIT_LOWRATE   = 4;
	localparam int SLD_OFS_W         = 5;
	localparam logic [7:0] SLD_RST_CAPTURE  = 8'h00;
	localparam logic [7:0] SLD_RST_SYNCMODE = 8'h00;
	localparam logic [7:0] SLD_RST_LANERATE = 8'h00;
	localparam logic [7:0] SLD_RST_LMFC_OFS = 8'h00;
	localparam logic [7:0] SLD_RST_SUBCLASS = 8'h20;
	// Link config: [1:0] F code (0:F1,1:F2,2:F4,3:F8+), [7:3] K/4-1
	localparam logic [7:0] SLD_RST_LINKCFG  = 8'h38;
	localparam logic [7:0] SLD_MIN_KQ_F1    = 8'h04;
	localparam logic [7:0] SLD_MIN_KQ_F2    = 8'h02;
	localparam logic [7:0] SLD_MIN_KQ_F4    = 8'h01;
	localparam logic [7:0] SLD_MIN_KQ_F8    = 8'h00;
	localparam int SLD_FIFO_DEPTH = 8;
endpackage

// ===== hdl/sld_core.sv
// Multiframe clock alignment, SYSREF capture, register file and sample FIFO
`timescale 1ns/10ps
`default_nettype none

module sld_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clock,   // Clock
	input  wire logic             i_rst_n,   // Async reset
	input  wire logic             i_ce,      // Clock enable
	input  wire logic             i_valid,   // Write valid
	output logic                  o_ready,   // Not full
	input  wire logic [WIDTH-1:0] i_data,    // Write data
	output logic                  o_valid,   // Not empty
	input  wire logic             i_ready,   // Drain ready
	output logic      [WIDTH-1:0] o_data     // Head data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic             push;
	logic             pop;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("FIFO depth must be a power of two");
	end

	assign push    = i_ce && i_valid && o_ready;
	assign pop     = i_ce && o_valid && i_ready;
	assign o_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
	assign o_valid = wp_r != rp_r;
	assign o_data  = mem[rp_r[AW-1:0]];

	always_ff @(posedge i_clock) begin
		if (push)
			mem[wp_r[AW-1:0]] <= i_data;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule

module sld_core
	import sld_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int DIV_W    = 3
) (
	input  wire logic                i_clock,        // 100 MHz clock
	input  wire logic                i_rst_n,        // Async reset, low
	input  wire logic                i_ce,           // Clock enable
	input  wire logic [11:0]         i_addr,         // Register address
	input  wire logic [7:0]          i_wdata,        // Write data
	input  wire logic                i_wr,           // Write strobe
	input  wire logic                i_rd,           // Read strobe
	output logic      [7:0]          o_rdata,        // Read data, next cycle
	input  wire logic                i_sysref,       // SYSREF level, sync
	input  wire logic                i_sysref_fall,  // SYSREF from falling-edge sampler
	input  wire logic [3:0]          i_setup_hold,   // Setup/hold detector levels
	input  wire logic                i_smp_valid,    // Sample valid
	output logic                     o_smp_ready,    // Sample ready
	input  wire logic [SAMPLE_W-1:0] i_smp_data,     // Sample word
	output logic                     o_tx_valid,     // Frame word valid
	input  wire logic                i_tx_ready,     // Link ready
	output logic      [SAMPLE_W-1:0] o_tx_data,      // Frame word
	output logic                     o_tx_mf_start,  // Word opens a multiframe
	output logic                     o_lmfc,         // Multiframe clock pulse
	output logic      [DIV_W-1:0]    o_div_phase,    // Sample divider phase
	output logic                     o_subclass1,    // Subclass 1 active
	output logic                     o_timestamp,    // Timestamp sync mode
	output logic                     o_low_rate      // Low line rate mode
);
	logic [7:0] capture_r;
	logic [7:0] syncmode_r;
	logic [7:0] lanerate_r;
	logic [7:0] ofs_r;
	logic [7:0] subclass_r;
	logic [7:0] linkcfg_r;
	logic [7:0] monitor_r;
	logic [7:0] rdata_nxt;
	logic [4:0] ofs_act_r;
	logic       sysref_d_r;
	logic       sysref_sel;
	logic       event_s;
	logic       align_s;
	logic       aligned_r;
	logic [9:0] tick_r;
	logic [7:0] frame_r;
	logic [7:0] k_frames;
	logic [9:0] ofs_ticks;
	logic [9:0] tick_lim;
	logic       mf_wrap;
	logic [DIV_W-1:0] div_r;
	logic       f_valid;
	logic       f_ready;
	logic [SAMPLE_W-1:0] f_data;
	logic       tx_pop;
	logic [7:0] kq_min;

	initial begin
		if (SAMPLE_W < 8 || DIV_W < 1)
			$error("Unsupported parameter values");
	end

	// Quarter frames moved per offset step: 1 for F=1, 2 for F=2, else 4
	function automatic logic [9:0] ofs_quarters(input logic [1:0] fcode);
		unique case (fcode)
			2'd0: ofs_quarters = 10'd1;
			2'd1: ofs_quarters = 10'd2;
			default: ofs_quarters = 10'd4;
		endcase
	endfunction

	// Offset in whole frames, folded into the multiframe
	// Folding keeps a large offset with a short K from underflowing the frame count
	function automatic logic [7:0] ofs_frames(input logic [4:0] ofs, input logic [1:0] fcode,
	                                          input logic [7:0] k);
		logic [9:0] quarters;
		quarters   = {5'h00, ofs} * ofs_quarters(fcode);
		ofs_frames = quarters[9:2] % k;
	endfunction

	// Least K/4-1 allowed for a given F code
	function automatic logic [7:0] min_kq(input logic [1:0] fcode);
		unique case (fcode)
			2'd0: min_kq = SLD_MIN_KQ_F1;
			2'd1: min_kq = SLD_MIN_KQ_F2;
			2'd2: min_kq = SLD_MIN_KQ_F4;
			default: min_kq = SLD_MIN_KQ_F8;
		endcase
	endfunction

	assign kq_min = min_kq(i_wdata[1:0]);

	// Register writes; K field clamped so illegal frame counts never land
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			capture_r  <= SLD_RST_CAPTURE;
			syncmode_r <= SLD_RST_SYNCMODE;
			lanerate_r <= SLD_RST_LANERATE;
			ofs_r      <= SLD_RST_LMFC_OFS;
			subclass_r <= SLD_RST_SUBCLASS;
			linkcfg_r  <= SLD_RST_LINKCFG;
		end else if (i_ce && i_wr) begin
			unique case (i_addr)
				SLD_ADDR_CAPTURE:  capture_r  <= i_wdata;
				SLD_ADDR_SYNCMODE: syncmode_r <= i_wdata;
				SLD_ADDR_LANERATE: lanerate_r <= i_wdata;
				SLD_ADDR_LMFC_OFS: ofs_r      <= {3'h0, i_wdata[4:0]};
				SLD_ADDR_SUBCLASS: subclass_r <= i_wdata;
				SLD_ADDR_LINKCFG: begin
					if ({3'h0, i_wdata[7:3]} < kq_min)
						linkcfg_r <= {kq_min[4:0], 1'b0, i_wdata[1:0]};
					else
						linkcfg_r <= {i_wdata[7:3], 1'b0, i_wdata[1:0]};
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (i_addr)
			SLD_ADDR_CAPTURE:  rdata_nxt = capture_r;
			SLD_ADDR_MONITOR:  rdata_nxt = monitor_r;
			SLD_ADDR_SYNCMODE: rdata_nxt = syncmode_r;
			SLD_ADDR_LANERATE: rdata_nxt = lanerate_r;
			SLD_ADDR_LMFC_OFS: rdata_nxt = ofs_r;
			SLD_ADDR_SUBCLASS: rdata_nxt = subclass_r;
			SLD_ADDR_LINKCFG:  rdata_nxt = linkcfg_r;
			SLD_ADDR_STATUS:   rdata_nxt = {4'h0, ofs_act_r[3:0] == 4'h0, aligned_r, f_valid, ~f_ready};
			default:           rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_ce)
			o_rdata <= i_rd ? rdata_nxt : 8'h00;
	end

	// Monitor captures detector levels continuously for software
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			monitor_r <= 8'h00;
		else if (i_ce)
			monitor_r <= {4'h0, i_setup_hold};
	end

	// SYSREF event detection
	assign sysref_sel = capture_r[SLD_BIT_EDGE] ? i_sysref_fall : i_sysref;
	assign event_s = capture_r[SLD_BIT_TRANS] ? (sysref_d_r && !sysref_sel)
	                                          : (!sysref_d_r && sysref_sel);
	// Subclass 0 ignores SYSREF; timestamp mode never resets the clocks
	assign align_s = event_s && subclass_r[SLD_BIT_SUBCLASS]
	                 && !syncmode_r[SLD_BIT_SYNCMODE];

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			sysref_d_r <= 1'b0;
		else if (i_ce)
			sysref_d_r <= sysref_sel;
	end

	// Offset counted in quarter frames, applied in whole frames, so F=1/F=2 step rules fall out
	assign k_frames  = {1'b0, linkcfg_r[7:3], 2'b00} + 8'd4;
	assign tick_lim  = 10'd3;
	// New offset is taken from the register at the alignment that loads it
	assign ofs_ticks = {2'b00, ofs_frames(ofs_r[4:0], linkcfg_r[1:0], k_frames)};
	// At or past the last frame wraps, so shrinking K never strands the counter
	assign mf_wrap   = (tick_r == tick_lim) && (frame_r >= k_frames - 8'd1);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_r    <= 10'h000;
			frame_r   <= 8'h00;
			ofs_act_r <= 5'h00;
			aligned_r <= 1'b0;
			o_lmfc    <= 1'b0;
		end else if (i_ce) begin
			if (align_s) begin
				ofs_act_r <= ofs_r[4:0];
				tick_r    <= 10'h000;
				frame_r   <= k_frames - 8'd1 - ofs_ticks[7:0];
				aligned_r <= 1'b1;
				o_lmfc    <= 1'b0;
			end else begin
				tick_r <= (tick_r == tick_lim) ? 10'h000 : tick_r + 10'd1;
				if (tick_r == tick_lim)
					frame_r <= mf_wrap ? 8'h00 : frame_r + 8'd1;
				o_lmfc <= mf_wrap;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			div_r <= '0;
		else if (i_ce)
			div_r <= align_s ? '0 : div_r + 1'b1;
	end

	sld_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (SLD_FIFO_DEPTH)
	) u_fifo (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_valid (i_smp_valid),
		.o_ready (f_ready),
		.i_data  (i_smp_data),
		.o_valid (f_valid),
		.i_ready (tx_pop),
		.o_data  (f_data)
	);

	assign tx_pop = !o_tx_valid || i_tx_ready;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tx_valid    <= 1'b0;
			o_tx_data     <= '0;
			o_tx_mf_start <= 1'b0;
			o_smp_ready   <= 1'b0;
			o_div_phase   <= '0;
			o_subclass1   <= 1'b1;
			o_timestamp   <= 1'b0;
			o_low_rate    <= 1'b0;
		end else if (i_ce) begin
			if (tx_pop) begin
				o_tx_valid    <= f_valid;
				o_tx_data     <= f_data;
				o_tx_mf_start <= f_valid && mf_wrap;
			end
			o_smp_ready <= f_ready;
			o_div_phase <= div_r;
			o_subclass1 <= subclass_r[SLD_BIT_SUBCLASS];
			o_timestamp <= syncmode_r[SLD_BIT_SYNCMODE];
			o_low_rate  <= lanerate_r[SLD_BIT_LOWRATE];
		end
	end

	chk_sub0_no_align: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && !subclass_r[SLD_BIT_SUBCLASS]) |-> !align_s)
		else $error("Alignment in subclass 0");
	chk_align_divider: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && align_s) |=> (div_r == '0 && aligned_r))
		else $error("Divider not reset by alignment");
	chk_offset_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && !align_s) |=> $stable(ofs_act_r))
		else $error("Offset changed without alignment");
	chk_lmfc_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && mf_wrap && !align_s) |=> o_lmfc)
		else $error("Multiframe pulse missing");
	chk_kq_legal: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		{3'h0, linkcfg_r[7:3]} >= min_kq(linkcfg_r[1:0]))
		else $error("Illegal frames per multiframe");
	chk_monitor_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && i_rd && i_addr == SLD_ADDR_MONITOR) |=> o_rdata == {4'h0, $past(i_setup_hold, 2)})
		else $error("Monitor readback wrong");
	chk_sync_mode: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && syncmode_r[SLD_BIT_SYNCMODE]) |-> !align_s)
		else $error("Timestamp mode reset clocks");
	chk_transition_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && event_s && capture_r[SLD_BIT_TRANS]) |-> ($past(sysref_sel) && !sysref_sel))
		else $error("Wrong transition used");

	// Control levels follow their register bits one cycle later
	chk_subclass_out: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_ce |=> o_subclass1 == $past(subclass_r[SLD_BIT_SUBCLASS]))
		else $error("Subclass output wrong");
	chk_low_rate_out: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_ce |=> o_low_rate == $past(lanerate_r[SLD_BIT_LOWRATE]))
		else $error("Low rate output wrong");
	chk_timestamp_out: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_ce |=> o_timestamp == $past(syncmode_r[SLD_BIT_SYNCMODE]))
		else $error("Sync mode output wrong");

	// Alignment loads the written offset and honours the selected clock edge
	chk_offset_active: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && align_s) |=> ofs_act_r == $past(ofs_r[4:0]))
		else $error("Offset not taken at alignment");
	chk_offset_load: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && align_s && linkcfg_r[1:0] == 2'd0 && ofs_r[4:2] == 3'h0) |=> frame_r == k_frames - 8'd1)
		else $error("Small offset moved a single-octet frame");
	chk_edge_select: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && align_s) |-> (capture_r[SLD_BIT_EDGE] ? (i_sysref_fall != sysref_d_r) : (i_sysref != sysref_d_r)))
		else $error("Alignment from wrong sampler");

	// A word leaving at a multiframe wrap carries the start flag
	chk_mf_start: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_ce && tx_pop && f_valid && mf_wrap) |=> o_tx_mf_start)
		else $error("Multiframe start flag missing");
endmodule

`default_nettype wire

// ===== tb/sld_rx_model.sv
// Link receiver model: takes frame words, stalls on command
`timescale 1ns/10ps
`default_nettype none

module sld_rx_model (
	input  wire logic i_clock, // Clock
	input  wire logic i_rst_n, // Reset, low
	input  wire logic i_stall, // Hold ready low
	input  wire logic i_valid, // Word valid
	output logic      o_ready, // Word ready
	output logic      o_got    // Word taken at this edge
);
	logic [1:0] ph_r;

	// Words taken straight off the link, no elastic delay
	assign o_got = i_valid & o_ready;

	// Ready drops one cycle in four, so the sender sees stalls
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_r    <= 2'h0;
			o_ready <= 1'b0;
		end else begin
			ph_r    <= ph_r + 2'h1;
			o_ready <= !i_stall && ph_r != 2'h3;
		end
	end
endmodule

`default_nettype wire

// ===== tb/sld_tb_top.sv
// Testbench for the alignment block
`timescale 1ns/10ps
`default_nettype none

module serial_link_deterministic_latency_tb_top;
	import sld_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        sr = 1'b0, srf = 1'b0, sv = 1'b0, stall = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wdata = 8'h00, rdata, v;
	logic [3:0]  sh = 4'h0;
	logic [15:0] sd = 16'h0000, txd, lf = 16'h2781;
	logic        txv, txr, mf, lmfc, s1, ts, lowr, srdy, got;
	logic [2:0]  dph, dp, dp0;
	int          err_total = 0, tests_run = 0, cyc = 0, per = 0, since = 0, d0, d;
	logic [15:0] q[$];

	always #5 clk = ~clk;

	sld_core i_dut (.i_clock(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sysref(sr), .i_sysref_fall(srf), .i_setup_hold(sh),
		.i_smp_valid(sv), .o_smp_ready(srdy), .i_smp_data(sd), .o_tx_valid(txv), .i_tx_ready(txr),
		.o_tx_data(txd), .o_tx_mf_start(mf), .o_lmfc(lmfc), .o_div_phase(dph), .o_subclass1(s1),
		.o_timestamp(ts), .o_low_rate(lowr));
	sld_rx_model i_rx (.i_clock(clk), .i_rst_n(rst_n), .i_stall(stall), .i_valid(txv), .o_ready(txr), .o_got(got));

	function logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function int kq(input int f);
		return f == 0 ? 20 : f == 1 ? 12 : f == 2 ? 8 : 4;
	endfunction
	// Offset steps per frame shrink as octets per frame grow; frame is 4 ticks
	function int oc(input int f, input int o);
		return f == 0 ? (o / 4) * 4 : f == 1 ? (o / 2) * 4 : o * 4;
	endfunction

	task test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr_reg(input logic [11:0] a, input logic [7:0] dt);
		@(posedge clk);
		addr  <= a;
		wdata <= dt;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task rd_reg(input logic [11:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask
	// Idle the line, wait a random phase, make one transition, count to the next pulse
	task sync_ev(input bit fsrc, input bit neg, output int n);
		@(posedge clk);
		if (fsrc) srf <= neg;
		else sr <= neg;
		lf = nx(lf);
		repeat (8 + lf[6:0]) @(posedge clk);
		if (fsrc) srf <= !neg;
		else sr <= !neg;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (n == 3) dp = dph;
		end while (!lmfc && n < 400);
	endtask
	task settle;
		@(posedge clk);
		#1;
	endtask
	task wait_lmfc;
		for (int i = 0; i < 400 && !lmfc; i++) @(posedge clk);
		@(posedge clk);
		#1 while (!lmfc && cyc < 60000) @(posedge clk) #1;
	endtask
	task push(input int n);
		repeat (n) begin
			@(posedge clk);
			lf = nx(lf);
			sd <= lf;
			sv <= srdy;
			@(posedge clk);
			sv <= 1'b0;
			@(posedge clk);
		end
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		since <= lmfc ? 1 : since + 1;
		if (lmfc) per <= since;
		if (sv && srdy) q.push_back(sd);
		if (got && q.size() != 0) chk("tx_data", q.pop_front(), txd);
		if (cyc == 60000) begin
			err_total++;
			test_done;
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(SLD_ADDR_SUBCLASS);
		chk("subclass_rst", SLD_RST_SUBCLASS, v);
		chk("subclass1_rst", 16'h0001, s1);
		rd_reg(SLD_ADDR_SYNCMODE);
		chk("syncmode_rst", 16'h0000, v);
		rd_reg(12'h123);
		chk("unmapped", 16'h0000, v);
		$display("test reset done");
		for (int f = 0; f < 4; f++) begin
			wr_reg(SLD_ADDR_LINKCFG, f[7:0]);
			rd_reg(SLD_ADDR_LINKCFG);
			chk("k_field", kq(f) / 4 - 1, v[7:3]);
			wr_reg(SLD_ADDR_LMFC_OFS, 8'h00);
			sync_ev(1'b0, 1'b0, d0);
			sync_ev(1'b0, 1'b0, d0);
			dp0 = dp;
			wait_lmfc;
			wait_lmfc;
			chk("lmfc_period", kq(f) * 4, per);
			wr_reg(SLD_ADDR_LMFC_OFS, 8'hE6);
			wait_lmfc;
			wait_lmfc;
			chk("ofs_deferred", kq(f) * 4, per);
			sync_ev(1'b0, 1'b0, d);
			chk("ofs_delay", oc(f, 6) % (kq(f) * 4), (d - d0 + kq(f) * 4) % (kq(f) * 4));
			chk("div_phase", dp0, dp);
		end
		$display("test offset done");
		wr_reg(SLD_ADDR_LINKCFG, 8'h39);
		rd_reg(SLD_ADDR_LINKCFG);
		chk("cfg_f2_k32", 16'h0039, v);
		wr_reg(SLD_ADDR_LINKCFG, SLD_RST_LINKCFG);
		wr_reg(SLD_ADDR_LMFC_OFS, 8'h00);
		sync_ev(1'b0, 1'b0, d0);
		wr_reg(SLD_ADDR_CAPTURE, 8'h10);
		sync_ev(1'b0, 1'b1, d);
		chk("fall_trans", d0, d);
		wr_reg(SLD_ADDR_CAPTURE, 8'h18);
		sync_ev(1'b1, 1'b1, d);
		chk("fall_edge_neg", d0, d);
		wr_reg(SLD_ADDR_CAPTURE, 8'h08);
		sync_ev(1'b1, 1'b0, d);
		chk("fall_edge_pos", d0, d);
		wr_reg(SLD_ADDR_CAPTURE, 8'h00);
		$display("test capture done");
		// System without latency needs picks subclass 0
		wr_reg(SLD_ADDR_SUBCLASS, 8'h00);
		settle;
		chk("subclass1_off", 16'h0000, s1);
		sync_ev(1'b0, 1'b0, d);
		wait_lmfc;
		chk("sc0_no_align", 16'd128, per);
		wr_reg(SLD_ADDR_SUBCLASS, 8'h20);
		wr_reg(SLD_ADDR_SYNCMODE, 8'h01);
		settle;
		chk("timestamp", 16'h0001, ts);
		sync_ev(1'b0, 1'b0, d);
		wait_lmfc;
		chk("ts_no_align", 16'd128, per);
		wr_reg(SLD_ADDR_SYNCMODE, 8'h00);
		wr_reg(SLD_ADDR_LANERATE, 8'h10);
		settle;
		chk("low_rate", 16'h0001, lowr);
		lf = nx(lf);
		sh <= lf[3:0];
		repeat (4) @(posedge clk);
		rd_reg(SLD_ADDR_MONITOR);
		chk("monitor", lf[3:0], v[3:0]);
		$display("test modes done");
		push(40);
		stall <= 1'b1;
		push(24);
		chk("fifo_refuse", 16'h0000, srdy);
		rd_reg(SLD_ADDR_STATUS);
		chk("fifo_full", 16'h0001, v[0]);
		stall <= 1'b0;
		for (int i = 0; i < 500 && q.size() != 0; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		rd_reg(SLD_ADDR_STATUS);
		chk("fifo_empty", 16'h0000, v[1]);
		chk("words_left", 16'h0000, q.size());
		$display("test stream done");
		test_done;
	end
endmodule

`default_nettype wire
